// *** rtl/i2c_disable_status.sv ***
// Disable status, General Call acknowledge and spike filter length registers.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - General call bit 1 drives SDA low in the ack slot of a General Call.
// - General call bit 0 blocks General Call acknowledge and its interrupt.
// - While enabled, status reads bit 0 as 1 and bits 2:1 as 0.
// - Bits 2:1 are valid only once bit 0 reads 0 after disabling.
// - Disable during matched slave-receive data phase sets the lost flag.
// - STOP before NACK in a receive data byte while disable is pending also sets the lost flag.
// - Disable without slave-receive data involvement leaves lost flag at 0.
// - Disable during slave address or receive data bytes sets busy-disable flag.
// - Busy-disable flag means a NACK was forced or transfer ended before disable.
// - STOP before NACK while disable is pending also sets busy-disable flag.
// - Disable with bus idle or other master active leaves busy flag at 0.
// - Bit 0 is 1 while enabled, 0 once fully inactive, readable anytime.
// - Spike filter length is writable only while the controller is disabled.
// - Writing a spike length below 1 stores 1.
// - General call setting applies only in slave mode.
module i2c_disable_status (
	// Clock, reset and clock enable
	input  wire logic                          mclk,
	input  wire logic                          sys_rst,
	input  wire logic                          clk_en,
	// AXI4-Lite slave
	input  wire logic [7:0]                    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [7:0]                    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Link to the rest of the controller
	input  wire logic                          ctrl_enable,
	input  wire i2c_dis_pkg::slave_act_t       slave_act,
	output logic                               sda_output_drive,
	output logic                               gen_call_event,
	output logic [i2c_dis_pkg::SPIKE_W-1:0]    spike_filter_length_field,
	// Interrupt
	output logic                               irq
);
	import i2c_dis_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	act_state_t         state_ff;
	act_state_t         nxt_state;
	logic               lost_ff;
	logic               nxt_lost;
	logic               busy_ff;
	logic               nxt_busy;
	logic               gc_ack_ff;
	logic [SPIKE_W-1:0] spike_ff;
	logic [IRQ_W-1:0]   irq_stat_ff;
	logic [IRQ_W-1:0]   irq_mask_ff;
	logic               en_prev_ff;

	// AXI bookkeeping.
	logic               aw_held_ff;
	logic [7:0]         aw_addr_ff;
	logic               w_held_ff;
	logic [31:0]        w_data_ff;
	logic [3:0]         w_strb_ff;
	logic               bvalid_ff;
	logic [1:0]         bresp_ff;
	logic               rvalid_ff;
	logic [31:0]        rdata_ff;
	logic [1:0]         rresp_ff;

	// Byte offset of the word addressed, with the lane bits dropped.
	function automatic logic [7:0] word_addr(input logic [7:0] a);
		return {a[7:2], 2'b00};
	endfunction

	// ------------------------------------------------------------
	// Write path decode
	// ------------------------------------------------------------
	logic        aw_take;
	logic        w_take;
	logic        wr_fire;
	logic [7:0]  wr_addr;
	logic        wr_lane0;
	logic        wr_gc;
	logic        wr_spike;
	logic        wr_stat;
	logic        wr_mask;
	logic        wr_ro;
	logic        wr_known;
	logic [7:0]  spike_wr_val;

	// Each channel is taken independently; the response waits for both.
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;
	assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff && clk_en;
	assign wr_addr       = word_addr(aw_addr_ff);
	assign wr_lane0      = w_strb_ff[0];
	assign wr_gc         = wr_fire && wr_lane0 && (wr_addr == OFF_GEN_CALL_ACK);
	assign wr_spike      = wr_fire && wr_lane0 && (wr_addr == OFF_SPIKE_LEN)
	                       && !ctrl_enable;
	assign wr_stat       = wr_fire && wr_lane0 && (wr_addr == OFF_IRQ_STATUS);
	assign wr_mask       = wr_fire && wr_lane0 && (wr_addr == OFF_IRQ_MASK);
	// The status word accepts the write with OKAY but stores nothing.
	assign wr_ro         = (wr_addr == OFF_DISABLE_STAT);
	assign wr_known      = wr_ro || (wr_addr == OFF_GEN_CALL_ACK)
	                       || (wr_addr == OFF_SPIKE_LEN) || (wr_addr == OFF_IRQ_STATUS)
	                       || (wr_addr == OFF_IRQ_MASK);
	// Values below the minimum clamp up so a write never stores a zero length; reset still loads 0.
	assign spike_wr_val  = (w_data_ff[7:0] < SPIKE_MIN) ? SPIKE_MIN : w_data_ff[7:0];

	// ------------------------------------------------------------
	// Write channel registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_held_ff  <= 1'b0;
			w_data_ff  <= WORD_ZERO;
			w_strb_ff  <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end else if (clk_en) begin
			if (aw_take) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [7:0]  rd_addr;
	logic [31:0] stat_word;
	logic [31:0] rd_word;
	logic        rd_known;

	// Reserved bits of the status word are constant zero.
	assign stat_word = {29'h0000_0000, lost_ff, busy_ff, (state_ff != ST_OFF)};
	assign rd_addr   = word_addr(s_axi_araddr);
	assign s_axi_arready = !rvalid_ff;

	// Address decode for reads; unmapped words answer SLVERR with zero data.
	always_comb begin
		rd_word  = WORD_ZERO;
		rd_known = 1'b1;
		if (rd_addr == OFF_DISABLE_STAT) begin
			rd_word = stat_word;
		end else if (rd_addr == OFF_GEN_CALL_ACK) begin
			rd_word = {31'h0000_0000, gc_ack_ff};
		end else if (rd_addr == OFF_SPIKE_LEN) begin
			rd_word = {24'h00_0000, spike_ff};
		end else if (rd_addr == OFF_IRQ_STATUS) begin
			rd_word = {29'h0000_0000, irq_stat_ff};
		end else if (rd_addr == OFF_IRQ_MASK) begin
			rd_word = {29'h0000_0000, irq_mask_ff};
		end else begin
			rd_known = 1'b0;
		end
	end

	// Read data is registered one cycle after the address is taken.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= WORD_ZERO;
			rresp_ff  <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_word;
				rresp_ff  <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// ------------------------------------------------------------
	// Disable tracking
	// ------------------------------------------------------------
	logic en_fall;
	logic in_rx_data;
	logic in_any_byte;

	assign en_fall     = en_prev_ff && !ctrl_enable;
	assign in_rx_data  = slave_act.slave_mode && slave_act.rx_data_phase;
	assign in_any_byte = slave_act.slave_mode && (slave_act.addr_phase || slave_act.rx_data_phase);

	// Flags are cleared on enable and collected only at the disable and while draining, so bits 2:1
	// settle no later than bit 0 drops and software may trust them once it reads 0.
	always_comb begin
		nxt_state = state_ff;
		nxt_lost  = lost_ff;
		nxt_busy  = busy_ff;
		case (state_ff)
			ST_OFF: begin
				if (ctrl_enable) begin
					nxt_state = ST_ENABLED;
					nxt_lost  = 1'b0;
					nxt_busy  = 1'b0;
				end
			end
			ST_ENABLED: begin
				nxt_lost = 1'b0;
				nxt_busy = 1'b0;
				if (en_fall) begin
					nxt_state = ST_DRAINING;
					// A disable with only other masters active or an idle bus
					// sets neither flag.
					nxt_lost  = in_rx_data;
					nxt_busy  = in_any_byte;
				end
			end
			ST_DRAINING: begin
				if (slave_act.stop_seen && in_any_byte) begin
					nxt_lost = lost_ff || in_rx_data;
					nxt_busy = 1'b1;
				end
				if (ctrl_enable) begin
					nxt_state = ST_ENABLED;
					nxt_lost  = 1'b0;
					nxt_busy  = 1'b0;
				end else if (slave_act.engine_idle) begin
					nxt_state = ST_OFF;
				end
			end
			default: nxt_state = ST_OFF;
		endcase
	end

	// State of the disable sequence.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff   <= ST_OFF;
			lost_ff    <= 1'b0;
			busy_ff    <= 1'b0;
			en_prev_ff <= 1'b0;
		end else if (clk_en) begin
			state_ff   <= nxt_state;
			lost_ff    <= nxt_lost;
			busy_ff    <= nxt_busy;
			en_prev_ff <= ctrl_enable;
		end
	end

	// ------------------------------------------------------------
	// General Call acknowledge and configuration
	// ------------------------------------------------------------
	logic gc_ack_ok;

	// The acknowledge drive is combinational so it lands inside the ack slot.
	assign gc_ack_ok        = gc_ack_ff && slave_act.slave_mode && ctrl_enable;
	assign sda_output_drive = gc_ack_ok && slave_act.gc_ack_slot;
	assign gen_call_event   = sda_output_drive;
	assign spike_filter_length_field = spike_ff;

	// Software settings.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			gc_ack_ff   <= 1'b0;
			spike_ff    <= SPIKE_RESET;
			irq_mask_ff <= IRQ_MASK_RESET;
		end else if (clk_en) begin
			if (wr_gc) begin
				gc_ack_ff <= w_data_ff[POS_GEN_CALL];
			end
			if (wr_spike) begin
				spike_ff <= spike_wr_val;
			end
			if (wr_mask) begin
				irq_mask_ff <= w_data_ff[IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	assign irq_set = {nxt_lost && !lost_ff, nxt_busy && !busy_ff, gen_call_event};
	assign irq_clr = wr_stat ? w_data_ff[IRQ_W-1:0] : {IRQ_W{1'b0}};
	assign irq     = |(irq_stat_ff & irq_mask_ff);

	// A set in the same cycle as a write-one clear wins, so no event is lost.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_ff <= {IRQ_W{1'b0}};
		end else if (clk_en) begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence seq_disable_start;
		(state_ff == ST_ENABLED) && en_fall;
	endsequence

	sequence seq_drain_done;
		(state_ff == ST_DRAINING) && !ctrl_enable && slave_act.engine_idle;
	endsequence

	chk_enabled_status: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_ff == ST_ENABLED) |-> (stat_word[2:1] == 2'b00 && stat_word[0]))
		else $error("status bits wrong while enabled");

	chk_gc_ack_drive: assert property (@(posedge mclk) disable iff (sys_rst)
		(gc_ack_ff && slave_act.slave_mode && ctrl_enable && slave_act.gc_ack_slot)
		|-> sda_output_drive)
		else $error("general call not acknowledged");

	chk_gc_nack: assert property (@(posedge mclk) disable iff (sys_rst)
		!gc_ack_ff |-> (!sda_output_drive && !gen_call_event))
		else $error("general call acknowledged while disabled");

	chk_gc_slave_only: assert property (@(posedge mclk) disable iff (sys_rst)
		!slave_act.slave_mode |-> !sda_output_drive)
		else $error("general call ack outside slave mode");

	chk_lost_on_disable: assert property (@(posedge mclk) disable iff (sys_rst)
		(seq_disable_start and (in_rx_data && clk_en)) |=> (lost_ff && busy_ff))
		else $error("lost flag not set on data-phase disable");

	chk_lost_clear_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		(seq_disable_start and (!in_any_byte && clk_en)) |=> (!lost_ff && !busy_ff))
		else $error("flag set on idle disable");

	chk_stop_flags: assert property (@(posedge mclk) disable iff (sys_rst)
		((state_ff == ST_DRAINING) && slave_act.stop_seen && in_any_byte && !ctrl_enable
		&& clk_en) |=> busy_ff)
		else $error("busy flag not set on stop while draining");

	chk_active_drop: assert property (@(posedge mclk) disable iff (sys_rst)
		(seq_drain_done and clk_en) |=> (!stat_word[0] && $stable(lost_ff)))
		else $error("active bit did not drop after draining");

	chk_spike_locked: assert property (@(posedge mclk) disable iff (sys_rst)
		(ctrl_enable && clk_en) |=> $stable(spike_ff))
		else $error("spike length changed while enabled");

	chk_spike_min: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_spike |=> (spike_ff >= SPIKE_MIN))
		else $error("spike length stored below minimum");

	chk_status_ro: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_fire && wr_ro && state_ff == ST_OFF && !ctrl_enable)
		|=> $stable(stat_word))
		else $error("status changed on write");

endmodule

// *** rtl/i2c_dis_pkg.sv ***
// Package of offsets, field layouts and types for the disable-status block.
package i2c_dis_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_GEN_CALL_ACK  = 8'h98;
	localparam logic [7:0] OFF_DISABLE_STAT  = 8'h9c;
	localparam logic [7:0] OFF_SPIKE_LEN     = 8'ha0;
	localparam logic [7:0] OFF_IRQ_STATUS    = 8'hb0;
	localparam logic [7:0] OFF_IRQ_MASK      = 8'hb4;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          POS_ACTIVE        = 0;
	localparam int          POS_BUSY_DIS      = 1;
	localparam int          POS_RX_LOST       = 2;
	localparam int          POS_GEN_CALL      = 0;
	localparam int          SPIKE_W           = 8;
	localparam int          IRQ_W             = 3;
	localparam logic [7:0]  SPIKE_RESET       = 8'h00;
	localparam logic [7:0]  SPIKE_MIN         = 8'h01;
	localparam logic [2:0]  IRQ_MASK_RESET    = 3'h0;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
	localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;

	// Interrupt event positions (same layout in status and mask).
	localparam int          IRQ_GEN_CALL      = 0;
	localparam int          IRQ_BUSY_DIS      = 1;
	localparam int          IRQ_RX_LOST       = 2;

	// Activity state of the slave engine as seen by this block.
	typedef enum logic [1:0] {
		ST_OFF,
		ST_ENABLED,
		ST_DRAINING
	} act_state_t;

	// Slave engine activity reported into this block.
	typedef struct packed {
		logic slave_mode;      // Unit is configured as a slave.
		logic addr_phase;      // Address byte of any slave transfer being received.
		logic rx_data_phase;   // Data phase of a matched slave-receive transfer.
		logic gc_ack_slot;     // Acknowledge slot after a General Call address.
		logic stop_seen;       // One-cycle pulse on a STOP condition.
		logic engine_idle;     // Slave engine has wound down completely.
	} slave_act_t;

endpackage

// *** verification/slave_engine_model.sv ***
// Behavioural model of the slave engine and the remote master seen by the block.
`timescale 1ns/1ps
module slave_engine_model (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	// Requests from the bench
	input  wire logic               ctrl_enable,
	input  wire logic               mode_req,
	input  wire logic [1:0]         phase_req,
	input  wire logic               stop_req,
	input  wire logic [3:0]         wind_down,
	// Activity towards the block
	output i2c_dis_pkg::slave_act_t slave_act
);
	import i2c_dis_pkg::*;
	logic [3:0] idle_cnt_ff;
	// Phases follow the remote master one cycle late, as a real engine would.
	// The wind-down count lets the engine go idle promptly or slowly.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			slave_act <= '0;
			idle_cnt_ff <= 4'h0;
		end else begin
			slave_act.slave_mode <= mode_req;
			slave_act.addr_phase <= (phase_req == 2'h1);
			slave_act.rx_data_phase <= (phase_req == 2'h2);
			slave_act.gc_ack_slot <= (phase_req == 2'h3);
			slave_act.stop_seen <= stop_req;
			idle_cnt_ff <= ctrl_enable ? wind_down : idle_cnt_ff - 4'(idle_cnt_ff != 4'h0);
			slave_act.engine_idle <= !ctrl_enable && (idle_cnt_ff == 4'h0);
		end
	end
endmodule

// *** verification/i2c_disable_status_bench.sv ***
// Self-checking bench for the disable-status block.
`timescale 1ns/1ps
module i2c_disable_status_bench;
	import i2c_dis_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                mclk, sys_rst, clk_en, ctrl_enable;
	logic [7:0]          s_axi_awaddr, s_axi_araddr;
	logic [31:0]         s_axi_wdata, s_axi_rdata;
	logic [3:0]          s_axi_wstrb;
	logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic                s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                s_axi_arready, s_axi_rvalid, sda_output_drive, gen_call_event, irq;
	logic [1:0]          s_axi_bresp, s_axi_rresp, phase_req;
	logic [SPIKE_W-1:0]  spike_filter_length_field;
	slave_act_t          slave_act;
	logic                mode_req, stop_req;
	logic [3:0]          wind_down;
	int                  num_errors, num_checks, n;
	logic [33:0]         rd_q[$];
	logic [31:0]         mask_q[$], got;
	logic [1:0]          wr_q[$];
	logic [7:0]          rnd;
	logic [7:0]          regs [5] = '{OFF_GEN_CALL_ACK, OFF_DISABLE_STAT, OFF_SPIKE_LEN,
	                                  OFF_IRQ_STATUS, OFF_IRQ_MASK};
	logic                c_mode [6] = '{1, 1, 1, 0, 1, 1};
	logic [1:0]          c_phase [6] = '{0, 1, 2, 1, 0, 0};
	logic [1:0]          c_stop [6] = '{0, 0, 0, 0, 2, 1};
	logic [1:0]          c_flag [6] = '{0, 1, 3, 0, 3, 1};

	i2c_disable_status u_i2c_disable_status (.mclk, .sys_rst, .clk_en,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ctrl_enable, .slave_act, .sda_output_drive,
		.gen_call_event, .spike_filter_length_field, .irq);
	slave_engine_model u_slave_engine_model (.mclk, .sys_rst, .ctrl_enable, .mode_req,
		.phase_req, .stop_req, .wind_down, .slave_act);

	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic end_of_test;
		if (num_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h", $time, m, g);
		end
	endtask
	task automatic cmp_rd(input logic [31:0] d, input logic [1:0] r);
		logic [33:0] e;
		logic [31:0] m;
		e = rd_q.pop_front();
		m = mask_q.pop_front();
		cmp_val({30'h0, r}, {30'h0, e[33:32]}, "read resp");
		cmp_val(d & m, e[31:0] & m, "read data");
	endtask
	// Each task starts on an edge of its own, so no signal is driven twice at once.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit aw_ok, w_ok;
		@(posedge mclk);
		wr_q.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge mclk);
			if (s_axi_awready && s_axi_awvalid) begin
				aw_ok = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_ok = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge mclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r, output logic [31:0] g);
		@(posedge mclk);
		rd_q.push_back({r, d});
		mask_q.push_back(m);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!(s_axi_arready && s_axi_arvalid));
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge mclk);
		g = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask

	// Responses are matched with the oldest note as they leave the bus.
	always @(posedge mclk) begin
		if (s_axi_bvalid && s_axi_bready) cmp_val({30'h0, s_axi_bresp}, {30'h0, wr_q.pop_front()},
			"write resp");
		if (s_axi_rvalid && s_axi_rready) cmp_rd(s_axi_rdata, s_axi_rresp);
	end

	// Watchdog; the tests need a few thousand cycles at most.
	initial begin
		#200_000;
		num_errors++;
		$display("MISMATCH %0t timeout", $time);
		end_of_test;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{mclk, clk_en, sys_rst} = 3'b011;
		{ctrl_enable, mode_req, stop_req, phase_req, wind_down} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		num_errors = 0;
		num_checks = 0;
		void'($urandom(32'h56b9_e828));
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (regs[i]) axi_rd(regs[i], WORD_ZERO, '1, RESP_OKAY, got);
		axi_rd(8'h10, WORD_ZERO, '1, RESP_SLVERR, got);
		axi_wr(8'h10, $urandom, RESP_SLVERR);
		// Spike length while disabled, then a write refused while enabled.
		rnd = 8'($urandom_range(255, 1));
		axi_wr(OFF_SPIKE_LEN, WORD_ZERO, RESP_OKAY);
		axi_rd(OFF_SPIKE_LEN, 32'h0000_0001, '1, RESP_OKAY, got);
		cmp_val(32'(spike_filter_length_field), 32'h0000_0001, "spike port");
		axi_wr(OFF_SPIKE_LEN, {24'($urandom), rnd}, RESP_OKAY);
		ctrl_enable <= 1'b1;
		axi_wr(OFF_SPIKE_LEN, {24'h0, ~rnd}, RESP_OKAY);
		axi_rd(OFF_SPIKE_LEN, {24'h0, rnd}, '1, RESP_OKAY, got);
		axi_wr(OFF_DISABLE_STAT, $urandom, RESP_OKAY);
		axi_rd(OFF_DISABLE_STAT, 32'h0000_0001, '1, RESP_OKAY, got);
		// General Call acknowledge, its interrupt and the slave-mode gate.
		mode_req <= 1'b1;
		phase_req <= 2'h3;
		repeat (3) @(posedge mclk);
		cmp_val(32'(sda_output_drive), 32'h0, "gc ack with bit clear");
		cmp_val(32'(gen_call_event), 32'h0, "gc event with bit clear");
		axi_wr(OFF_GEN_CALL_ACK, 32'h0000_0001, RESP_OKAY);
		cmp_val(32'(sda_output_drive), 32'h1, "gc ack");
		cmp_val(32'(irq), 32'h0, "masked irq");
		mode_req <= 1'b0;
		repeat (3) @(posedge mclk);
		cmp_val(32'(sda_output_drive), 32'h0, "gc ack outside slave mode");
		phase_req <= 2'h0;
		axi_wr(OFF_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
		cmp_val(32'(irq), 32'h1, "gc irq");
		axi_wr(OFF_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
		cmp_val(32'(irq), 32'h0, "gc irq cleared");
		axi_rd(OFF_GEN_CALL_ACK, 32'h0000_0001, '1, RESP_OKAY, got);
		axi_wr(OFF_IRQ_MASK, 32'h0000_0006, RESP_OKAY);
		// Disable in each bus situation; flags are read once bit 0 has fallen.
		for (int i = 0; i < 6; i++) begin
			ctrl_enable <= 1'b1;
			mode_req <= c_mode[i];
			phase_req <= c_phase[i];
			wind_down <= (c_stop[i] != 2'h0) ? 4'hc : 4'(i);
			axi_rd(OFF_DISABLE_STAT, 32'h0000_0001, '1, RESP_OKAY, got);
			ctrl_enable <= 1'b0;
			repeat (3) @(posedge mclk);
			phase_req <= c_stop[i];
			stop_req <= (c_stop[i] != 2'h0);
			@(posedge mclk);
			stop_req <= 1'b0;
			phase_req <= 2'h0;
			n = 0;
			do begin
				axi_rd(OFF_DISABLE_STAT, WORD_ZERO, WORD_ZERO, RESP_OKAY, got);
				n++;
			end while (got[0] !== 1'b0 && n < 40);
			axi_rd(OFF_DISABLE_STAT, {29'h0, c_flag[i], 1'b0}, '1, RESP_OKAY, got);
			cmp_val(32'(irq), 32'(c_flag[i] != 2'h0), "flag irq");
			axi_wr(OFF_IRQ_MASK, WORD_ZERO, RESP_OKAY);
			cmp_val(32'(irq), 32'h0, "irq masked");
			axi_wr(OFF_IRQ_MASK, 32'h0000_0006, RESP_OKAY);
			axi_wr(OFF_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
			cmp_val(32'(irq), 32'h0, "irq cleared");
		end
		end_of_test;
	end
endmodule
